// ===== verilog/mil_pkg.sv
// constants shared by the interrupt logic: register map, fields, reset values
package mil_pkg;

  // ----------------------------------------------------------------
  // bus and core widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int PC_W   = 15;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PENABLE_ONE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PENABLE_TWO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PREQUEST_ONE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PREQUEST_TWO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PIN_CONFIG  = 8'h14;

  // ----------------------------------------------------------------
  // irq_control_reg fields and pin configuration field
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_TMR0_EN   = 5;
  localparam int BIT_PIN_EN    = 4;
  localparam int BIT_CHANGE_EN = 3;
  localparam int BIT_TMR0_FLAG = 2;
  localparam int BIT_PIN_FLAG  = 1;
  localparam int BIT_CHANGE_FLAG = 0;
  localparam int BIT_EDGE_SEL  = 0;

  // ----------------------------------------------------------------
  // implemented bits of the peripheral registers, reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] MASK_PERIPH_ONE = 8'hCF;
  localparam logic [REG_W-1:0] MASK_PERIPH_TWO = 8'h09;
  localparam logic [REG_W-1:0] RST_REG         = 8'h00;
  localparam logic             RST_EDGE_SEL    = 1'b1;

  // ----------------------------------------------------------------
  // vectoring and context save
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]  IRQ_VECTOR      = 15'h0004;
  localparam logic [REG_W-1:0] STATUS_SAVE_MASK = 8'hE7; // drops timeout, powerdown bits
  localparam int               LAT_MIN_CYC     = 3;
  localparam int               LAT_MAX_CYC     = 5;

endpackage : mil_pkg

// ===== verilog/mil_irq_logic.sv
// interrupt logic: enables, flags, vectoring, context shadows, pin edge, wake
//
// Behaviour
// - any reset clears every enable, so nothing vectors until software enables
// - vector needs global enable, own enable, and peripheral enable for peripherals
// - flags set on their condition whatever the enable bits say
// - flags live in control register and two peripheral request registers
// - taking an interrupt flushes prefetched instruction and clears global enable
// - taking pushes pc, saves context to shadows, loads vector 0004h
// - with global enable clear events only flag and wake from sleep; serviced once re-enabled
// - return pops address, restores shadows, sets global enable
// - synchronous source reaches vector three or four instruction cycles later
// - asynchronous source reaches vector three to five instruction cycles later
// - latency same for one-cycle and two-cycle instructions
// - pin flag may set during Q4-Q1; sampled once per cycle at Q1
// - on wake branch to vector if global enable set, else continue
// - instruction after sleep always executes before the branch
// - external pin gives edge-triggered interrupt gated by its own enable
// - edge select set means rising edge, clear means falling edge
// - selected pin edge sets pin flag; vectors with global and pin enables
// - shadows hold work, status less timeout/powerdown, bank, pointers, pc latch
// - change summary flag is read-only, clears when all change flags clear
`timescale 1ns/1ps

module mil_irq_logic (
  input  wire logic                       clk,               // 50 MHz system clock
  input  wire logic                       sys_rst,           // sync reset, high
  input  wire logic                       clk_en,            // freezes all state when low
  input  wire logic [mil_pkg::ADDR_W-1:0] avs_address,       // byte address
  input  wire logic                       avs_read,          // read request
  input  wire logic                       avs_write,         // write request
  input  wire logic [mil_pkg::DATA_W-1:0] avs_writedata,     // write data
  input  wire logic [3:0]                 avs_byteenable,    // byte lanes
  output logic      [mil_pkg::DATA_W-1:0] avs_readdata,      // read data
  output logic                            avs_waitrequest,   // stall
  input  wire logic                       ext_pin,           // external interrupt pin
  input  wire logic                       tmr0_evt,          // timer0 overflow pulse
  input  wire logic [mil_pkg::REG_W-1:0]  periph_evt_one,    // peripheral pulses, set one
  input  wire logic [mil_pkg::REG_W-1:0]  periph_evt_two,    // peripheral pulses, set two
  input  wire logic                       change_any,        // any change flag still set
  input  wire logic                       core_q1,           // first quarter of a cycle
  input  wire logic                       core_asleep,       // core is in sleep
  input  wire logic                       core_return_from_isr_instr,       // return_from_isr_instr pulse
  input  wire logic [mil_pkg::PC_W-1:0]   core_pc,           // current program counter
  input  wire logic [mil_pkg::REG_W-1:0]  core_work,         // working register
  input  wire logic [mil_pkg::REG_W-1:0]  core_status,       // status register
  input  wire logic [mil_pkg::REG_W-1:0]  core_bank,         // bank_select_reg
  input  wire logic [15:0]                core_ind_ptr0,     // indirect_pointer_regs 0
  input  wire logic [15:0]                core_ind_ptr1,     // indirect_pointer_regs 1
  input  wire logic [mil_pkg::REG_W-1:0]  core_pc_high,      // pc_high_latch
  output logic                            irq_take,          // flush, push, load vector
  output logic [mil_pkg::PC_W-1:0]        stack_push_addr,   // pc to push
  output logic [mil_pkg::PC_W-1:0]        pc_load_addr,      // vector address
  output logic                            ctx_restore,       // pop and restore pulse
  output logic                            core_wake,         // leave sleep pulse
  output logic [mil_pkg::REG_W-1:0]       shadow_work,       // saved working register
  output logic [mil_pkg::REG_W-1:0]       shadow_status,     // saved status
  output logic [mil_pkg::REG_W-1:0]       shadow_bank,       // saved bank select
  output logic [15:0]                     shadow_ind_ptr0,   // saved pointer 0
  output logic [15:0]                     shadow_ind_ptr1,   // saved pointer 1
  output logic [mil_pkg::REG_W-1:0]       shadow_pc_high     // saved pc latch
);
  import mil_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              global_irq_enable;
    logic              periph_irq_enable;
    logic              tmr0_en;
    logic              pin_en;
    logic              chg_en;
    logic              tmr0_f;
    logic              pin_f;
    logic              chg_f;
    logic              edge_sel;
    logic [REG_W-1:0]  pe1;
    logic [REG_W-1:0]  pe2;
    logic [REG_W-1:0]  pr1;
    logic [REG_W-1:0]  pr2;
    logic              pin_s1;
    logic              pin_s2;
    logic              pin_s3;
    logic              pin_lvl;
    logic              skip;
    logic              take;
    logic              ret;
    logic              wake;
    logic [PC_W-1:0]   push_addr;
    logic [REG_W-1:0]  sh_work;
    logic [REG_W-1:0]  sh_status;
    logic [REG_W-1:0]  sh_bank;
    logic [15:0]       sh_ptr0;
    logic [15:0]       sh_ptr1;
    logic [REG_W-1:0]  sh_pch;
    logic              waitreq;
    logic [REG_W-1:0]  rdata;
  } mil_state_type;

  mil_state_type st_r;
  mil_state_type st_nxt;

  logic             pin_edge;    // qualified edge on the synchronised pin
  logic             pending;     // an enabled flag is set
  logic             wr_go;       // write completes this edge
  logic [REG_W-1:0] wbyte;       // low byte of write data
  logic [REG_W-1:0] ctl_view;    // irq_control_reg as read

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  // control register image
  assign ctl_view = {st_r.global_irq_enable, st_r.periph_irq_enable, st_r.tmr0_en, st_r.pin_en,
                     st_r.chg_en, st_r.tmr0_f, st_r.pin_f, st_r.chg_f};
  assign wbyte    = avs_writedata[REG_W-1:0];
  assign wr_go    = avs_write && !st_r.waitreq && avs_byteenable[0];

  // stable level change once second and third stages agree
  // rising when edge select set, falling when clear
  assign pin_edge = (st_r.pin_s2 == st_r.pin_s3) && (st_r.pin_s3 != st_r.pin_lvl) &&
                    (st_r.pin_s3 == st_r.edge_sel);

  // own enable per source, peripheral enable over peripheral sets
  assign pending = (st_r.tmr0_en && st_r.tmr0_f) || (st_r.pin_en && st_r.pin_f) ||
                   (st_r.chg_en && st_r.chg_f) ||
                   (st_r.periph_irq_enable && (|((st_r.pe1 & st_r.pr1) | (st_r.pe2 & st_r.pr2))));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.take = 1'b0;
    st_nxt.ret  = 1'b0;
    st_nxt.wake = 1'b0;

    // pin synchroniser, first stage read only by the second
    st_nxt.pin_s1 = ext_pin;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.pin_s3 = st_r.pin_s2;
    if (st_r.pin_s2 == st_r.pin_s3) begin
      st_nxt.pin_lvl = st_r.pin_s3;
    end

    // software writes, low byte only
    if (wr_go) begin
      case (avs_address)
        OFS_IRQ_CONTROL: begin
          st_nxt.global_irq_enable     = wbyte[BIT_GLOBAL_EN];
          st_nxt.periph_irq_enable    = wbyte[BIT_PERIPH_EN];
          st_nxt.tmr0_en = wbyte[BIT_TMR0_EN];
          st_nxt.pin_en  = wbyte[BIT_PIN_EN];
          st_nxt.chg_en  = wbyte[BIT_CHANGE_EN];
          // flags cleared only by a written zero
          st_nxt.tmr0_f  = wbyte[BIT_TMR0_FLAG];
          st_nxt.pin_f   = wbyte[BIT_PIN_FLAG];
        end
        OFS_PENABLE_ONE:  st_nxt.pe1 = wbyte & MASK_PERIPH_ONE;
        OFS_PENABLE_TWO:  st_nxt.pe2 = wbyte & MASK_PERIPH_TWO;
        OFS_PREQUEST_ONE: st_nxt.pr1 = wbyte & MASK_PERIPH_ONE;
        OFS_PREQUEST_TWO: st_nxt.pr2 = wbyte & MASK_PERIPH_TWO;
        OFS_PIN_CONFIG:   st_nxt.edge_sel = wbyte[BIT_EDGE_SEL];
        default: begin
        end
      endcase
    end

    // events set flags whatever the enables; set wins over a clear
    // flags kept in control and two request registers
    // with global enable clear an event records its flag and can wake the core, but never vectors
    if (tmr0_evt) begin
      st_nxt.tmr0_f = 1'b1;
    end
    // selected edge sets the pin flag
    // pin source is edge-triggered and gated by its enable
    if (pin_edge) begin
      st_nxt.pin_f = 1'b1;
    end
    st_nxt.pr1 = st_nxt.pr1 | (periph_evt_one & MASK_PERIPH_ONE);
    st_nxt.pr2 = st_nxt.pr2 | (periph_evt_two & MASK_PERIPH_TWO);
    // read-only summary follows the individual change flags
    st_nxt.chg_f = change_any;

    // return sets global enable and restores shadows
    if (core_return_from_isr_instr) begin
      st_nxt.global_irq_enable = 1'b1;
      st_nxt.ret = 1'b1;
    end

    // wake on any enabled source; vector only if global enable set
    // the instruction after sleep runs before the branch
    if (core_asleep) begin
      if (pending) begin
        st_nxt.wake = 1'b1;
        st_nxt.skip = 1'b1;
      end
    // request sampled once per instruction cycle at Q1
    end else if (core_q1) begin
      if (st_r.skip) begin
        st_nxt.skip = 1'b0;
      // latency fixed by Q1 sampling, not by the instruction
      // pin path adds the synchroniser to the same sampling
      // take at Q1 regardless of one or two cycle instruction
      end else if (st_r.global_irq_enable && pending && !core_return_from_isr_instr) begin
        st_nxt.take = 1'b1;
        st_nxt.global_irq_enable  = 1'b0;
        // push pc, save context, load vector
        st_nxt.push_addr = core_pc;
        // context set saved, timeout and powerdown bits dropped
        st_nxt.sh_work   = core_work;
        st_nxt.sh_status = core_status & STATUS_SAVE_MASK;
        st_nxt.sh_bank   = core_bank;
        st_nxt.sh_ptr0   = core_ind_ptr0;
        st_nxt.sh_ptr1   = core_ind_ptr1;
        st_nxt.sh_pch    = core_pc_high;
      end
    end

    // bus slave: one wait cycle, answer on the second edge
    if ((avs_read || avs_write) && st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      case (avs_address)
        OFS_IRQ_CONTROL:  st_nxt.rdata = ctl_view;
        OFS_PENABLE_ONE:  st_nxt.rdata = st_r.pe1;
        OFS_PENABLE_TWO:  st_nxt.rdata = st_r.pe2;
        OFS_PREQUEST_ONE: st_nxt.rdata = st_r.pr1;
        OFS_PREQUEST_TWO: st_nxt.rdata = st_r.pr2;
        OFS_PIN_CONFIG:   st_nxt.rdata = {{(REG_W-1){1'b0}}, st_r.edge_sel};
        default:          st_nxt.rdata = RST_REG;
      endcase
    end else begin
      st_nxt.waitreq = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // every enable and flag cleared by reset
      st_r          <= '0;
      st_r.edge_sel <= RST_EDGE_SEL;
      st_r.waitreq  <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register, except pc_load_addr which is the constant IRQ_VECTOR
  // ----------------------------------------------------------------
  assign avs_readdata    = {{(DATA_W-REG_W){1'b0}}, st_r.rdata};
  assign avs_waitrequest = st_r.waitreq;
  assign irq_take        = st_r.take;
  assign stack_push_addr = st_r.push_addr;
  assign pc_load_addr    = IRQ_VECTOR;
  assign ctx_restore     = st_r.ret;
  assign core_wake       = st_r.wake;
  assign shadow_work     = st_r.sh_work;
  assign shadow_status   = st_r.sh_status;
  assign shadow_bank     = st_r.sh_bank;
  assign shadow_ind_ptr0 = st_r.sh_ptr0;
  assign shadow_ind_ptr1 = st_r.sh_ptr1;
  assign shadow_pc_high  = st_r.sh_pch;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_clears_en: assert property (
    @(posedge clk) sys_rst |=> (!st_r.global_irq_enable && !st_r.pin_en && st_r.pr1 == RST_REG))
    else $error("enables not cleared by reset");

  a_take_needs_en: assert property (
    @(posedge clk) disable iff (sys_rst) $rose(st_r.take) |-> $past(st_r.global_irq_enable) && $past(pending))
    else $error("vector taken without enables");

  a_flag_on_event: assert property (
    @(posedge clk) disable iff (sys_rst) (clk_en && tmr0_evt) |=> st_r.tmr0_f)
    else $error("timer flag not set by event");

  a_take_clears_gie: assert property (
    @(posedge clk) disable iff (sys_rst) st_r.take |-> !st_r.global_irq_enable)
    else $error("global enable still set after take");

  a_take_saves_ctx: assert property (
    @(posedge clk) disable iff (sys_rst)
      (clk_en && st_nxt.take) |=> (st_r.push_addr == $past(core_pc) &&
       st_r.sh_status == ($past(core_status) & STATUS_SAVE_MASK)))
    else $error("context not saved on take");

  a_return_sets_gie: assert property (
    @(posedge clk) disable iff (sys_rst) (clk_en && core_return_from_isr_instr) |=> st_r.global_irq_enable && st_r.ret)
    else $error("return did not set global enable");

  a_pin_edge_flag: assert property (
    @(posedge clk) disable iff (sys_rst) (clk_en && pin_edge) |=> st_r.pin_f)
    else $error("pin edge lost");

  a_summary_tracks: assert property (
    @(posedge clk) disable iff (sys_rst) clk_en |=> st_r.chg_f == $past(change_any))
    else $error("summary flag does not track change flags");

  a_wake_then_run: assert property (
    @(posedge clk) disable iff (sys_rst) st_r.wake |-> !st_r.take)
    else $error("vector taken in the wake cycle");

  a_bus_one_wait: assert property (
    @(posedge clk) disable iff (sys_rst)
      (clk_en && (avs_read || avs_write) && st_r.waitreq) |=> !avs_waitrequest)
    else $error("bus answer late");

  a_take_at_q1: assert property (
    @(posedge clk) disable iff (sys_rst) $rose(st_r.take) |-> $past(core_q1))
    else $error("vector taken off a Q1 edge");

  a_gie_off_blocks: assert property (
    @(posedge clk) disable iff (sys_rst) (clk_en && !st_r.global_irq_enable) |=> !st_r.take)
    else $error("vector taken with global enable clear");

  a_take_one_pulse: assert property (
    @(posedge clk) disable iff (sys_rst) (clk_en && st_r.take) |=> !st_r.take)
    else $error("take pulse longer than one clock");

  a_skip_blocks_take: assert property (
    @(posedge clk) disable iff (sys_rst) (clk_en && st_r.skip) |=> !st_r.take)
    else $error("vector taken before the instruction after sleep");

  a_wake_needs_pend: assert property (
    @(posedge clk) disable iff (sys_rst)
      $rose(st_r.wake) |-> $past(core_asleep) && $past(pending))
    else $error("wake without an enabled pending flag");

  a_pin_edge_once: assert property (
    @(posedge clk) disable iff (sys_rst) (clk_en && pin_edge) |=> !pin_edge)
    else $error("one pin edge counted twice");

endmodule : mil_irq_logic

// ===== tb/mil_core_model.sv
// behavioural model of the core fetch unit facing the interrupt logic
`timescale 1ns/1ps

module mil_core_model #(
  parameter int QP = 4                            // clocks per instruction cycle
) (
  input  wire logic                     clk,         // system clock
  input  wire logic                     sys_rst,     // sync reset, high
  input  wire logic                     irq_take,    // take pulse
  input  wire logic [mil_pkg::PC_W-1:0] push_pc,     // pc to push
  input  wire logic [mil_pkg::PC_W-1:0] vec_pc,      // vector to load
  input  wire logic                     ctx_restore, // pop pulse
  input  wire logic                     core_wake,   // wake pulse
  input  wire logic                     sleep_cmd,   // bench asks for sleep
  input  wire logic                     ret_cmd,     // bench asks for return
  output logic                          core_q1,     // first quarter pulse
  output logic                          core_asleep, // core sleeping
  output logic                          core_return_from_isr_instr, // return instruction pulse
  output logic [mil_pkg::PC_W-1:0]      core_pc,     // program counter
  output logic [mil_pkg::PC_W-1:0]      q1_pc        // pc seen at last q1
);
  import mil_pkg::*;
  logic [3:0]      qcnt_r;   // quarter counter
  logic [PC_W-1:0] stack_r;  // one-level return stack
  // -----------------------------------------------------------
  // instruction timing and fetch
  // -----------------------------------------------------------
  assign core_q1 = (qcnt_r == 4'h0) && !sys_rst;
  // count cycles, step pc, follow take and return
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      qcnt_r      <= 4'h0;
      core_pc     <= 15'h0100;
      q1_pc       <= 15'h0000;
      stack_r     <= 15'h0000;
      core_asleep <= 1'b0;
      core_return_from_isr_instr <= 1'b0;
    end else begin
      qcnt_r      <= (qcnt_r == 4'(QP - 1)) ? 4'h0 : qcnt_r + 4'h1;
      core_return_from_isr_instr <= ret_cmd;
      if (core_q1) q1_pc <= core_pc;
      if (irq_take) begin
        stack_r <= push_pc;
        core_pc <= vec_pc;
      end else if (ctx_restore) core_pc <= stack_r;
      else if (core_q1 && !core_asleep) core_pc <= core_pc + 15'h0001;
      if (core_wake) core_asleep <= 1'b0;
      else if (sleep_cmd) core_asleep <= 1'b1;
    end
  end
endmodule : mil_core_model

// ===== tb/tb.sv
// self-checking bench for the interrupt logic
`timescale 1ns/1ps

module tb;
  import mil_pkg::*;
  localparam int QP = 4;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = 8'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              ext_pin = 1'b0;
  logic              tmr0_evt = 1'b0;
  logic [REG_W-1:0]  periph_evt_one = 8'h00;
  logic [REG_W-1:0]  periph_evt_two = 8'h00;
  logic              change_any = 1'b0;
  logic              sleep_cmd = 1'b0;
  logic              ret_cmd = 1'b0;
  logic              clk_en = 1'b1;
  logic              core_q1, core_asleep, core_return_from_isr_instr, irq_take, ctx_restore, core_wake;
  logic [PC_W-1:0]   core_pc, q1_pc, stack_push_addr, pc_load_addr;
  logic [REG_W-1:0]  shadow_work, shadow_status, shadow_bank, shadow_pc_high;
  logic [15:0]       shadow_ind_ptr0, shadow_ind_ptr1;
  logic [31:0]       rd;
  int                bad_count = 0;
  int                n_checks = 0;
  int                n, nq, k;
  // 50 MHz clock
  always #10 clk = ~clk;
  // device and core model, work, bank, pointer 0 and pc latch inputs derived from pc
  mil_irq_logic i_dut (.clk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_pin, .tmr0_evt,
    .periph_evt_one, .periph_evt_two, .change_any, .core_q1, .core_asleep, .core_return_from_isr_instr,
    .core_pc, .core_work(core_pc[7:0] ^ 8'h3C), .core_status(8'hFF),
    .core_bank(core_pc[7:0]), .core_ind_ptr0({core_pc[7:0], 8'hA5}),
    .core_ind_ptr1(16'h1234), .core_pc_high({1'b0, core_pc[14:8]}), .irq_take,
    .stack_push_addr, .pc_load_addr, .ctx_restore, .core_wake, .shadow_work,
    .shadow_status, .shadow_bank, .shadow_ind_ptr0, .shadow_ind_ptr1, .shadow_pc_high);
  mil_core_model #(.QP(QP)) i_core (.clk, .sys_rst, .irq_take, .push_pc(stack_push_addr),
    .vec_pc(pc_load_addr), .ctx_restore, .core_wake, .sleep_cmd, .ret_cmd, .core_q1,
    .core_asleep, .core_return_from_isr_instr, .core_pc, .q1_pc);
  // -----------------------------------------------------------
  // access and compare tasks
  // -----------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h0, d};
    for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++) @(posedge clk);
    chk("bus_wait", 1, i < 20);
    if (i >= 20) tally_and_finish;
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, exp}, rd);
  endtask : rchk
  task automatic evt(input logic t, input logic [7:0] p1, input logic [7:0] p2);
    @(posedge clk);
    tmr0_evt       <= t;
    periph_evt_one <= p1;
    periph_evt_two <= p2;
    @(posedge clk);
    tmr0_evt       <= 1'b0;
    periph_evt_one <= 8'h00;
    periph_evt_two <= 8'h00;
  endtask : evt
  task automatic no_take;
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      seen = seen | irq_take;
    end
    chk("no_take", 0, seen);
  endtask : no_take
  task automatic wait_take(input int lim);
    nq = 0;
    for (n = 1; n <= lim; n++) begin
      @(posedge clk);
      if (irq_take === 1'b1) break;
      if (core_q1 === 1'b1) nq++;
    end
    chk("take_in_time", 1, n <= lim);
    if (n > lim) tally_and_finish;
  endtask : wait_take
  task automatic take_ok;
    chk("pc_load_addr", IRQ_VECTOR, pc_load_addr);
    chk("stack_push_addr", q1_pc, stack_push_addr);
    chk("shadow_work", q1_pc[7:0] ^ 8'h3C, shadow_work);
    chk("shadow_status", 8'hE7, shadow_status);
    chk("shadow_ind_ptr0", {q1_pc[7:0], 8'hA5}, shadow_ind_ptr0);
    chk("shadow_bank", q1_pc[7:0], shadow_bank);
    chk("shadow_ind_ptr1", 16'h1234, shadow_ind_ptr1);
    chk("shadow_pc_high", {1'b0, q1_pc[14:8]}, shadow_pc_high);
  endtask : take_ok
  task automatic ret;
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    for (n = 0; n < 10 && core_return_from_isr_instr !== 1'b1; n++) @(posedge clk);
    chk("return_from_isr_instr_seen", 1, n < 10);
    if (n >= 10) tally_and_finish;
    @(posedge clk);
    chk("ctx_restore", 1, ctx_restore);
  endtask : ret
  // -----------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(OFS_IRQ_CONTROL, 8'h00, "ctrl_reset");
    for (k = 1; k < 5; k++) rchk(8'(4 * k), 8'h00, "periph_reset");
    rchk(OFS_PIN_CONFIG, 8'h01, "edge_reset");
    rchk(8'h18, 8'h00, "unmapped");
    avs_byteenable <= 4'h0;
    bus(1'b1, OFS_PENABLE_ONE, 8'hFF);
    avs_byteenable <= 4'hF;
    rchk(OFS_PENABLE_ONE, 8'h00, "lane_off_write");
    evt(1'b1, 8'hFF, 8'hFF);
    no_take();
    rchk(OFS_IRQ_CONTROL, 8'h04, "ctrl_flag");
    rchk(OFS_PREQUEST_ONE, MASK_PERIPH_ONE, "preq_one");
    rchk(OFS_PREQUEST_TWO, MASK_PERIPH_TWO, "preq_two");
    bus(1'b1, OFS_PREQUEST_ONE, 8'h00);
    bus(1'b1, OFS_PREQUEST_TWO, 8'h00);
    rchk(OFS_PREQUEST_ONE, 8'h00, "preq_clear");
    bus(1'b1, OFS_IRQ_CONTROL, 8'h24);
    no_take();
    bus(1'b1, OFS_IRQ_CONTROL, 8'hA4);
    wait_take(3 * QP);
    take_ok();
    rchk(OFS_IRQ_CONTROL, 8'h24, "gie_cleared");
    ret();
    wait_take(3 * QP);
    bus(1'b1, OFS_IRQ_CONTROL, 8'h20);
    ret();
    rchk(OFS_IRQ_CONTROL, 8'hA0, "gie_restored");
    no_take();
    evt(1'b1, 8'h00, 8'h00);
    wait_take(LAT_MAX_CYC * QP);
    take_ok();
    bus(1'b1, OFS_IRQ_CONTROL, 8'h20);
    ret();
    bus(1'b1, OFS_PENABLE_ONE, 8'h01);
    evt(1'b0, 8'h01, 8'h00);
    bus(1'b1, OFS_IRQ_CONTROL, 8'h80);
    no_take();
    bus(1'b1, OFS_IRQ_CONTROL, 8'hC0);
    wait_take(3 * QP);
    bus(1'b1, OFS_PREQUEST_ONE, 8'h00);
    ret();
    for (k = 1; k >= 0; k--) begin
      bus(1'b1, OFS_PIN_CONFIG, 8'(k));
      ext_pin <= !k[0];
      repeat (8) @(posedge clk);
      bus(1'b1, OFS_IRQ_CONTROL, 8'h00);
      ext_pin <= k[0];
      repeat (8) @(posedge clk);
      rchk(OFS_IRQ_CONTROL, 8'h02, "pin_edge");
      bus(1'b1, OFS_IRQ_CONTROL, 8'h00);
      ext_pin <= !k[0];
      repeat (8) @(posedge clk);
      rchk(OFS_IRQ_CONTROL, 8'h00, "pin_other_edge");
    end
    bus(1'b1, OFS_IRQ_CONTROL, 8'h90);
    ext_pin <= 1'b0;
    wait_take(LAT_MAX_CYC * QP);
    bus(1'b1, OFS_IRQ_CONTROL, 8'h10);
    ret();
    for (k = 0; k < 2; k++) begin
      bus(1'b1, OFS_IRQ_CONTROL, k ? 8'hA0 : 8'h20);
      @(posedge clk);
      sleep_cmd <= 1'b1;
      @(posedge clk);
      sleep_cmd <= 1'b0;
      evt(1'b1, 8'h00, 8'h00);
      for (n = 0; n < 40 && core_wake !== 1'b1; n++) @(posedge clk);
      chk("wake", 1, n < 40);
      if (n >= 40) tally_and_finish;
      if (k == 0) no_take();
      else wait_take(4 * QP);
      if (k == 1) chk("q1_before_take", 1, nq >= 2);
      bus(1'b1, OFS_IRQ_CONTROL, 8'h20);
      if (k == 1) ret();
    end
    change_any <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(OFS_IRQ_CONTROL, 8'hA1, "summary_set");
    bus(1'b1, OFS_IRQ_CONTROL, 8'hA0);
    rchk(OFS_IRQ_CONTROL, 8'hA1, "summary_ro");
    change_any <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(OFS_IRQ_CONTROL, 8'hA0, "summary_clear");
    clk_en <= 1'b0;
    evt(1'b1, 8'h00, 8'h00);
    clk_en <= 1'b1;
    rchk(OFS_IRQ_CONTROL, 8'hA0, "frozen_evt");
    bus(1'b1, OFS_IRQ_CONTROL, 8'hF8);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(OFS_IRQ_CONTROL, 8'h00, "ctrl_rerst");
    tally_and_finish();
  end
endmodule : tb
